// File: core/shrp_defs.svh
`ifndef SHRP_DEFS_SVH
`define SHRP_DEFS_SVH

// frame layout, counted in captured bits
`define SHRP_FRAME_BITS   5'd16
`define SHRP_RW_POS       0
`define SHRP_ADDR_LSB     1
`define SHRP_ADDR_MSB     6
`define SHRP_DATA_LSB     8
`define SHRP_DATA_MSB     15
`define SHRP_DUMMY_CNT    5'd8
`define SHRP_SREG_MSB     15
`define SHRP_RD_OP        1'b1
`define SHRP_WR_OP        1'b0

// register array
`define SHRP_REG_COUNT    64
`define SHRP_REG_DEFAULT  8'h00

// timing
`define SHRP_MCLK_HZ      10000000
`define SHRP_RST_HOLD_MS  10
`define SHRP_RST_CNT_W    17

// synchroniser idle levels: {rst_pin_n, cs_n, sclk, serial_in}
`define SHRP_SYNC_IDLE    4'hc

`endif

// File: core/shrp_pkg.sv
package shrp_pkg;
	// transaction phase
	typedef enum logic [1:0] {
		SHRP_IDLE,
		SHRP_SHIFT,
		SHRP_HOLD
	} shrp_state_t;
endpackage

// File: core/shrp_sync.sv
`timescale 1ns/1ns
`include "shrp_defs.svh"

module shrp_sync #(
	parameter int           WIDTH = 4,
	parameter logic [3:0]   IDLE  = `SHRP_SYNC_IDLE
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               resetn,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0]   async_in,
	output logic      [WIDTH-1:0]   sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	////////////////////////////////////////////////////////////////////////
	// two stages per bit; the first stage feeds only the second
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_comb begin
				meta_next[g] = async_in[g];
				sync_next[g] = meta_reg[g];
			end

			always_ff @(posedge mclk) begin
				if (!resetn) begin
					meta_reg[g] <= IDLE[g];
					sync_reg[g] <= IDLE[g];
				end else begin
					meta_reg[g] <= meta_next[g];
					sync_reg[g] <= sync_next[g];
				end
			end
		end
	endgenerate

	assign sync_out = sync_reg;

endmodule // shrp_sync

// File: core/shrp_port.sv
// Behaviour
// - a transaction is exactly sixteen serial clock bit periods
// - serial input is captured on each of the first sixteen rising serial clock edges
// - nothing is committed before all sixteen bits are captured
// - read data on serial output changes on falling serial clock edges
// - first bit chooses operation: zero writes, one reads
// - bits two to seven carry address, bit zero first
// - eighth bit is a dummy, ignored for reads and writes
// - bits nine to sixteen carry write data, bit zero first
// - write data is held and loaded only when chip select goes high
// - read data appears in periods nine to sixteen, bit zero first
// - reset pin low beyond ten milliseconds restores register defaults
`timescale 1ns/1ns
`include "shrp_defs.svh"

module shrp_port #(
	parameter int RST_HOLD_CYC = `SHRP_RST_HOLD_MS * (`SHRP_MCLK_HZ / 1000)
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// serial host pins
	input  wire logic         cs_n,
	input  wire logic         sclk,
	input  wire logic         serial_in,
	output logic              serial_out,
	output logic              serial_out_oe,
	// hardware reset pin
	input  wire logic         rst_pin_n,
	// register write notification
	output logic              wr_pulse,
	output logic [5:0]        wr_addr,
	output logic [7:0]        wr_data,
	// defaults being applied
	output logic              defaults_active
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation

	logic [3:0] pins_s;
	logic       rst_pin_s;
	logic       cs_s;
	logic       sclk_s;
	logic       sin_s;

	shrp_sync #(
		.WIDTH (4),
		.IDLE  (`SHRP_SYNC_IDLE)
	) u_sync (
		.mclk     (mclk),
		.resetn   (resetn),
		.async_in ({rst_pin_n, cs_n, sclk, serial_in}),
		.sync_out (pins_s)
	);

	assign rst_pin_s = pins_s[3];
	assign cs_s      = pins_s[2];
	assign sclk_s    = pins_s[1];
	assign sin_s     = pins_s[0];

	// picks one bit of a byte; used for read shifting and its check
	function automatic logic pick_bit(input logic [7:0] b, input logic [4:0] cnt);
		logic [2:0] idx;
		idx = cnt[2:0];
		return b[idx];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// edge detection on synchronised levels

	logic sclk_d_reg;
	logic cs_d_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			cs_d_reg   <= cs_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s & sclk_d_reg;
	assign cs_rise   = cs_s & ~cs_d_reg;

	////////////////////////////////////////////////////////////////////////
	// long hold on the reset pin

	localparam logic [`SHRP_RST_CNT_W-1:0] RST_LIM = `SHRP_RST_CNT_W'(RST_HOLD_CYC);

	logic [`SHRP_RST_CNT_W-1:0] rst_cnt_reg;
	logic [`SHRP_RST_CNT_W-1:0] rst_cnt_next;
	logic                       dflt;

	// counts while the pin is low, saturates at the limit
	always_comb begin
		rst_cnt_next = rst_cnt_reg;
		if (rst_pin_s)
			rst_cnt_next = '0;
		else if (rst_cnt_reg != RST_LIM)
			rst_cnt_next = rst_cnt_reg + 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			rst_cnt_reg <= '0;
		else
			rst_cnt_reg <= rst_cnt_next;
	end

	assign dflt = (rst_cnt_reg == RST_LIM);

	////////////////////////////////////////////////////////////////////////
	// frame receiver

	shrp_pkg::shrp_state_t state_reg;
	shrp_pkg::shrp_state_t state_next;
	logic [4:0]            cnt_reg;
	logic [4:0]            cnt_next;
	logic [15:0]           sreg_reg;
	logic [15:0]           sreg_next;
	logic                  rw_reg;
	logic                  rw_next;
	logic                  commit;

	logic [7:0] mem_reg  [`SHRP_REG_COUNT];
	logic [7:0] mem_next [`SHRP_REG_COUNT];

	// bits shift in from the top so the first bit lands at position zero
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sreg_next  = sreg_reg;
		rw_next    = rw_reg;
		commit     = 1'b0;
		case (state_reg)
			shrp_pkg::SHRP_IDLE: begin
				if (!cs_s) begin
					state_next = shrp_pkg::SHRP_SHIFT;
					if (sclk_rise) begin
						sreg_next = {sin_s, sreg_reg[`SHRP_SREG_MSB:1]};
						rw_next   = sin_s;
						cnt_next  = 5'd1;
					end
				end
			end
			shrp_pkg::SHRP_SHIFT: begin
				if (cs_s) begin
					state_next = shrp_pkg::SHRP_IDLE;
					cnt_next   = '0;
				end else if (sclk_rise) begin
					sreg_next = {sin_s, sreg_reg[`SHRP_SREG_MSB:1]};
					if (cnt_reg == '0)
						rw_next = sin_s;
					cnt_next = cnt_reg + 5'd1;
					if (cnt_next == `SHRP_FRAME_BITS)
						state_next = shrp_pkg::SHRP_HOLD;
				end
			end
			shrp_pkg::SHRP_HOLD: begin
				// extra edges after the sixteenth are not captured
				if (cs_rise) begin
					state_next = shrp_pkg::SHRP_IDLE;
					cnt_next   = '0;
					commit     = (rw_reg == `SHRP_WR_OP);
				end
			end
			default: begin
				state_next = shrp_pkg::SHRP_IDLE;
				cnt_next   = '0;
			end
		endcase
		if (cs_s)
			cnt_next = '0;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= shrp_pkg::SHRP_IDLE;
			cnt_reg   <= '0;
			sreg_reg  <= '0;
			rw_reg    <= `SHRP_WR_OP;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sreg_reg  <= sreg_next;
			rw_reg    <= rw_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register array; dummy bit at position seven is never used

	logic [5:0] frame_addr;
	logic [7:0] frame_data;

	assign frame_addr = sreg_reg[`SHRP_ADDR_MSB:`SHRP_ADDR_LSB];
	assign frame_data = sreg_reg[`SHRP_DATA_MSB:`SHRP_DATA_LSB];

	// a long reset outranks a commit landing in the same cycle
	genvar r;
	generate
		for (r = 0; r < `SHRP_REG_COUNT; r++) begin : g_reg
			always_comb begin
				mem_next[r] = mem_reg[r];
				if (dflt)
					mem_next[r] = `SHRP_REG_DEFAULT;
				else if (commit && frame_addr == 6'(r))
					mem_next[r] = frame_data;
			end

			always_ff @(posedge mclk) begin
				if (!resetn)
					mem_reg[r] <= `SHRP_REG_DEFAULT;
				else
					mem_reg[r] <= mem_next[r];
			end
		end
	endgenerate

	logic       wr_pulse_reg;
	logic [5:0] wr_addr_reg;
	logic [7:0] wr_data_reg;

	// pulse marks a load; address and data follow every commit, even one a long reset blocks
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_pulse_reg <= 1'b0;
			wr_addr_reg  <= '0;
			wr_data_reg  <= '0;
		end else begin
			wr_pulse_reg <= commit & ~dflt;
			wr_addr_reg  <= commit ? frame_addr : wr_addr_reg;
			wr_data_reg  <= commit ? frame_data : wr_data_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read-back driver

	logic [7:0] rd_byte_reg;
	logic [7:0] rd_byte_next;
	logic       sout_reg;
	logic       sout_next;
	logic       oe_reg;
	logic       oe_next;
	logic       rd_slot;

	// slot is the window between the eighth and sixteenth rising edges
	assign rd_slot = (rw_reg == `SHRP_RD_OP) && !cs_s &&
		(cnt_reg >= `SHRP_DUMMY_CNT) && (cnt_reg < `SHRP_FRAME_BITS);

	// byte is fetched at the dummy edge, giving the output a half period
	always_comb begin
		rd_byte_next = rd_byte_reg;
		sout_next    = sout_reg;
		oe_next      = oe_reg;
		if (state_reg == shrp_pkg::SHRP_SHIFT && sclk_rise && cnt_reg == 5'd7)
			// after eight shifts the address sits one above the direction bit
			rd_byte_next = mem_reg[sreg_next[`SHRP_DATA_MSB-1:`SHRP_DATA_LSB+1]];
		if (sclk_fall && rd_slot) begin
			sout_next = pick_bit(rd_byte_reg, cnt_reg);
			oe_next   = 1'b1;
		end
		if (cs_s)
			oe_next = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rd_byte_reg <= '0;
			sout_reg    <= 1'b0;
			oe_reg      <= 1'b0;
		end else begin
			rd_byte_reg <= rd_byte_next;
			sout_reg    <= sout_next;
			oe_reg      <= oe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign serial_out      = sout_reg;
	assign serial_out_oe   = oe_reg;
	assign wr_pulse        = wr_pulse_reg;
	assign wr_addr         = wr_addr_reg;
	assign wr_data         = wr_data_reg;
	assign defaults_active = dflt;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_cnt_cleared: assert property (cs_s |=> cnt_reg == '0)
		else $error("bit counter not cleared while chip select high");

	a_rise_counts: assert property (
		state_reg == shrp_pkg::SHRP_SHIFT && !cs_s && sclk_rise
		|=> cnt_reg == $past(cnt_reg) + 5'd1)
		else $error("rising edge not captured");

	a_frame_len: assert property (
		$rose(state_reg == shrp_pkg::SHRP_HOLD) |-> cnt_reg == `SHRP_FRAME_BITS)
		else $error("hold entered at wrong bit count");

	a_no_early_commit: assert property (
		wr_pulse_reg |-> $past(state_reg) == shrp_pkg::SHRP_HOLD)
		else $error("commit before sixteen bits");

	a_commit_on_cs: assert property (
		state_reg == shrp_pkg::SHRP_HOLD && cs_rise && rw_reg == `SHRP_WR_OP && !dflt
		|=> wr_pulse_reg ##1 mem_reg[$past(frame_addr, 2)] == $past(frame_data, 2))
		else $error("write not loaded on chip select high");

	a_read_no_write: assert property (
		wr_pulse_reg |-> $past(rw_reg) == `SHRP_WR_OP)
		else $error("read frame wrote a register");

	a_wr_fields: assert property (
		wr_pulse_reg |-> wr_addr_reg == $past(sreg_reg[6:1])
			&& wr_data_reg == $past(sreg_reg[15:8]))
		else $error("write fields misplaced");

	a_partial_drop: assert property (
		state_reg == shrp_pkg::SHRP_SHIFT && cs_s |=> !wr_pulse_reg [*2])
		else $error("partial frame committed");

	a_out_on_fall: assert property (
		$changed(sout_reg) |-> $past(sclk_fall))
		else $error("serial output changed off a falling edge");

	a_read_bit: assert property (
		sclk_fall && rd_slot |=> oe_reg
			&& sout_reg == pick_bit(rd_byte_reg, $past(cnt_reg)))
		else $error("wrong read bit presented");

	a_long_reset: assert property (
		dflt |=> mem_reg[0] == `SHRP_REG_DEFAULT && !wr_pulse_reg)
		else $error("defaults not restored");

	c_write_frame: cover property (wr_pulse_reg);
	c_read_frame: cover property (
		oe_reg && rw_reg == `SHRP_RD_OP ##[1:200] cs_s);
	c_abort: cover property (state_reg == shrp_pkg::SHRP_SHIFT && cs_s);
	c_defaults: cover property ($rose(dflt));

endmodule // shrp_port

// File: tb/shrp_host.sv
`timescale 1ns/1ns

// host side of the serial port; pins change just after mclk rises
module shrp_host (
	// clock
	input  wire logic mclk,
	// serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	// idle: deselected, sclk parked low
	initial begin
		cs_n      = 1'b1;
		sclk      = 1'b0;
		serial_in = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// one frame of nbits, returns at the cs_n rise; sclk only runs inside frames
	task automatic xfer(input logic [15:0] f, input int nbits, output logic [7:0] rd,
		output logic oe);
		oe = 1'b1;
		rd = 8'h00;
		tick(4); // gap between frames
		cs_n = 1'b0;
		tick(4);
		for (int i = 0; i < nbits; i++) begin
			serial_in = f[i];
			tick(4);
			sclk = 1'b1;
			tick(4);
			// sampled late in the high half, the device answers 3 mclk after a fall
			if (i >= 8) begin
				rd[i-8] = serial_out;
				oe = oe & serial_out_oe;
			end
			sclk = 1'b0;
		end
		serial_in = ~serial_in; // no stale level once the frame ends
		tick(6);
		cs_n = 1'b1;
	endtask
endmodule // shrp_host

// File: tb/test_shrp_port.sv
`timescale 1ns/1ns

module test_shrp_port;
	localparam int HOLD = 20; // short pin-reset hold keeps the run brief

	logic       mclk            = 1'b0;
	logic       resetn          = 1'b0;
	logic       rst_pin_n       = 1'b1;
	logic       cs_n;
	logic       sclk;
	logic       serial_in;
	logic       serial_out;
	logic       serial_out_oe;
	logic       wr_pulse;
	logic       defaults_active;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	int         miscompares     = 0;
	int         n_compared      = 0;
	int         n_wr            = 0;
	int         cycles          = 0;

	always #50 mclk = ~mclk;

	shrp_port #(.RST_HOLD_CYC(HOLD)) u_dut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n),
		.sclk(sclk), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .rst_pin_n(rst_pin_n), .wr_pulse(wr_pulse),
		.wr_addr(wr_addr), .wr_data(wr_data), .defaults_active(defaults_active));

	shrp_host u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));

	// count write pulses; the cycle ceiling cuts a hang short
	always @(posedge mclk) begin
		cycles++;
		if (wr_pulse === 1'b1)
			n_wr++;
		if (cycles == 12000) begin
			miscompares++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// write: nothing lands while cs_n is low, one pulse soon after it rises
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic dm);
		logic [7:0] rd;
		logic       oe;
		int         n0;
		n0 = n_wr;
		u_host.xfer({d, dm, a, 1'b0}, 16, rd, oe);
		check("early_write", 8'(n_wr - n0), 8'h00);
		wait_cyc(8);
		check("write_count", 8'(n_wr - n0), 8'h01);
		check("wr_addr", {2'b00, wr_addr}, {2'b00, a});
		check("wr_data", wr_data, d);
	endtask

	// read: byte returns bit zero first and causes no write
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] rd;
		logic       oe;
		int         n0;
		n0 = n_wr;
		u_host.xfer({8'ha5, 1'b1, a, 1'b1}, 16, rd, oe);
		wait_cyc(8);
		check("read_data", rd, exp);
		check("read_oe", {7'h00, oe}, 8'h01);
		check("read_no_write", 8'(n_wr - n0), 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// a walking address bit, each with its own byte and dummy level
	task automatic t_walk();
		for (int k = 0; k < 6; k++)
			wr(6'h01 << k, (8'h01 << k) ^ 8'h5a, 1'(k));
		wr(6'h3f, 8'ha5, 1'b0);
		for (int k = 0; k < 6; k++)
			rd_chk(6'h01 << k, (8'h01 << k) ^ 8'h5a);
		rd_chk(6'h3f, 8'ha5);
		rd_chk(6'h00, 8'h00); // untouched register still at default
	endtask

	// short frames are dropped and the next full frame still works
	task automatic t_partial();
		logic [7:0] rd;
		logic       oe;
		int         n0;
		wr(6'h03, 8'h5a, 1'b1);
		n0 = n_wr;
		u_host.xfer({8'hff, 1'b0, 6'h03, 1'b0}, 15, rd, oe);
		u_host.xfer({8'hff, 1'b0, 6'h03, 1'b0}, 1, rd, oe);
		wait_cyc(8);
		check("partial_write", 8'(n_wr - n0), 8'h00);
		rd_chk(6'h03, 8'h5a);
	endtask

	// a short pin pulse does nothing, a long one restores defaults
	task automatic t_pin_reset();
		rst_pin_n = 1'b0;
		wait_cyc(10);
		check("short_pin", {7'h00, defaults_active}, 8'h00);
		rst_pin_n = 1'b1;
		wait_cyc(6);
		rst_pin_n = 1'b0;
		wait_cyc(HOLD + 8);
		check("long_pin", {7'h00, defaults_active}, 8'h01);
		rst_pin_n = 1'b1;
		wait_cyc(8);
		check("pin_release", {7'h00, defaults_active}, 8'h00);
		rd_chk(6'h03, 8'h00);
	endtask

	initial begin
		wait_cyc(4);
		resetn = 1'b1;
		check("reset_oe", {7'h00, serial_out_oe}, 8'h00);
		check("reset_pulse", {7'h00, wr_pulse}, 8'h00);
		check("reset_wr_data", wr_data, 8'h00);
		t_walk();
		t_partial();
		t_pin_reset();
		summarize();
	end
endmodule // test_shrp_port
